// ===== rtl/eepec_params.svh
// Address map, field positions and storage reset values of the EEPROM control block
`ifndef EEPEC_PARAMS_SVH
`define EEPEC_PARAMS_SVH

// ------------------------------------------------------------
// Address map
// ------------------------------------------------------------
`define EEPEC_ARRAY_FIRST   16'h0600
`define EEPEC_ARRAY_LAST    16'h07ff
`define EEPEC_NVCFG_ADDR    16'hfe1c
`define EEPEC_SECURE_FIRST  16'h08f0
`define EEPEC_SECURE_LAST   16'h08ff

// ------------------------------------------------------------
// Array geometry
// ------------------------------------------------------------
`define EEPEC_ARRAY_BYTES   512
`define EEPEC_IDX_MSB       8
`define EEPEC_BLK_MSB       8
`define EEPEC_BLK_LSB       7
`define EEPEC_NUM_BLOCKS    4

// ------------------------------------------------------------
// Configuration byte fields and values
// ------------------------------------------------------------
`define EEPEC_CFG_SEC_BIT   4
`define EEPEC_CFG_BP_MSB    3
`define EEPEC_CFG_BP_LSB    0
`define EEPEC_ERASED_BYTE   8'hff
`define EEPEC_NVCFG_INIT    8'h10
`define EEPEC_CTRL_RESET    4'h0

`endif

// ===== rtl/eepec_pkg.sv
// Types shared by the EEPROM program and erase control block
`default_nettype none

package eepec_pkg;

  // ------------------------------------------------------------
  // Operation selected by the two erase-mode bits
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EEPEC_BYTE_PROGRAM = 2'b00,
    EEPEC_BYTE_ERASE   = 2'b01,
    EEPEC_BLOCK_ERASE  = 2'b10,
    EEPEC_BULK_ERASE   = 2'b11
  } eepec_mode_t;

  // ------------------------------------------------------------
  // Array control register
  // ------------------------------------------------------------
  typedef struct packed {
    logic erase_mode_high;
    logic erase_mode_low;
    logic bus_latch_enable;
    logic high_voltage_enable;
  } eepec_ctrl_t;

  // ------------------------------------------------------------
  // Bus access to the array and to the configuration byte
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } eepec_access_t;

endpackage

`default_nettype wire

// ===== rtl/eepec_top.sv
// EEPROM array with program, erase, block protection and security control
`default_nettype none

`include "eepec_params.svh"

module eepec_top (
  input  wire logic                   MCLK_IN,
  input  wire logic                   SYS_RST_IN,
  input  wire logic                   CTRL_WR_IN,
  input  wire eepec_pkg::eepec_ctrl_t CTRL_WDATA_IN,
  input  wire logic                   MEM_WR_IN,
  input  wire logic                   MEM_RD_IN,
  input  wire eepec_pkg::eepec_access_t MEM_ACCESS_IN,
  output logic [7:0]                  MEM_RDATA_OUT,
  output eepec_pkg::eepec_ctrl_t      CTRL_STATUS_OUT,
  output logic [7:0]                  VOL_CFG_OUT,
  output logic                        LATCH_VALID_OUT,
  output logic                        PUMP_ON_OUT,
  output logic                        HV_APPLIED_OUT
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Factory state: array erased, configuration unprotected and unsecured.
  // Reset leaves the stored cells alone; they are nonvolatile.
  // Given at declaration, so each update process alone owns its cells
  logic [7:0]                       mem [0:`EEPEC_ARRAY_BYTES-1] =
                                        '{default: `EEPEC_ERASED_BYTE};
  logic [7:0]                       nonvolatile_config_byte = `EEPEC_NVCFG_INIT;
  logic [7:0]                       volatile_array_config;
  eepec_pkg::eepec_ctrl_t           array_control_reg;
  logic [15:0]                      latched_addr;
  logic [7:0]                       latched_data;
  logic                             latched_valid;
  logic                             nonarray_wr;
  logic                             hv_applied;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  logic [15:0] acc_addr;
  logic        acc_in_array;
  logic        acc_is_nvcfg;
  logic        acc_secure;
  logic        sec_armed;
  logic        acc_valid;

  assign acc_addr     = MEM_ACCESS_IN.addr;
  assign acc_in_array = (acc_addr >= `EEPEC_ARRAY_FIRST) &&
                        (acc_addr <= `EEPEC_ARRAY_LAST);
  assign acc_is_nvcfg = (acc_addr == `EEPEC_NVCFG_ADDR);
  assign acc_secure   = (acc_addr >= `EEPEC_SECURE_FIRST) && (acc_addr <= `EEPEC_SECURE_LAST);
  // Armed from the stored byte itself, so it cannot be undone by a later write
  assign sec_armed    = ~nonvolatile_config_byte[`EEPEC_CFG_SEC_BIT];
  assign acc_valid    = (acc_in_array || acc_is_nvcfg) &&
                        !(sec_armed && acc_secure);

  // ------------------------------------------------------------
  // Operation qualification on the latched target
  // ------------------------------------------------------------
  eepec_pkg::eepec_mode_t                        mode;
  logic [`EEPEC_NUM_BLOCKS-1:0]                  block_protect_bit;
  logic [`EEPEC_BLK_MSB-`EEPEC_BLK_LSB:0]        lat_block;
  logic [`EEPEC_IDX_MSB:0]                       lat_idx;
  logic                                          lat_in_array;
  logic                                          lat_is_nvcfg;
  logic                                          lat_secure;
  logic                                          lat_prot;
  logic                                          op_allowed;

  // Erase-mode bits pick the operation; both clear means program
  assign mode = eepec_pkg::eepec_mode_t'({array_control_reg.erase_mode_high,
                                          array_control_reg.erase_mode_low});
  assign block_protect_bit = volatile_array_config[`EEPEC_CFG_BP_MSB:`EEPEC_CFG_BP_LSB];
  // Array base is 512-aligned, so the low address bits index it directly
  assign lat_idx      = latched_addr[`EEPEC_IDX_MSB:0];
  assign lat_block    = latched_addr[`EEPEC_BLK_MSB:`EEPEC_BLK_LSB];
  assign lat_in_array = (latched_addr >= `EEPEC_ARRAY_FIRST) &&
                        (latched_addr <= `EEPEC_ARRAY_LAST);
  assign lat_is_nvcfg = (latched_addr == `EEPEC_NVCFG_ADDR);
  assign lat_secure   = (latched_addr >= `EEPEC_SECURE_FIRST) &&
                        (latched_addr <= `EEPEC_SECURE_LAST);
  assign lat_prot     = block_protect_bit[lat_block];

  // Protect bits come from the volatile copy only, never the stored byte
  always_comb begin
    op_allowed = 1'b0;
    unique case (mode)
      eepec_pkg::EEPEC_BYTE_PROGRAM,
      eepec_pkg::EEPEC_BYTE_ERASE: begin
        op_allowed = (lat_in_array && !lat_prot) ||
                     (lat_is_nvcfg && !sec_armed);
      end
      eepec_pkg::EEPEC_BLOCK_ERASE: begin
        op_allowed = lat_in_array && !lat_prot && !sec_armed;
      end
      eepec_pkg::EEPEC_BULK_ERASE: begin
        op_allowed = lat_in_array && !(|block_protect_bit) && !sec_armed;
      end
    endcase
    // Checked last so the secured range overrides every mode
    if (sec_armed && lat_secure) begin
      op_allowed = 1'b0;
    end
  end

  // High voltage only reaches the array for a latched, permitted target
  logic next_hv_applied;
  logic hv_start;

  assign next_hv_applied = array_control_reg.high_voltage_enable &&
                           array_control_reg.bus_latch_enable &&
                           latched_valid && op_allowed;
  // One-cycle start strobe: the cells are touched on this edge only
  assign hv_start        = next_hv_applied && !hv_applied;

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      hv_applied <= 1'b0;
    end else begin
      // Registered so the switch never glitches on a decode change
      hv_applied <= next_hv_applied;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic ctrl_wr_ok;

  // A latch that still waits for its target blocks control writes
  assign ctrl_wr_ok = CTRL_WR_IN &&
                      !(array_control_reg.bus_latch_enable && !latched_valid);

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      array_control_reg <= `EEPEC_CTRL_RESET;
    end else if (ctrl_wr_ok) begin
      // Mode bits freeze under voltage so a running operation cannot change
      if (!array_control_reg.high_voltage_enable) begin
        array_control_reg.erase_mode_high <= CTRL_WDATA_IN.erase_mode_high;
        array_control_reg.erase_mode_low  <= CTRL_WDATA_IN.erase_mode_low;
      end
      // Latch holds while voltage is on, giving it time to decay
      array_control_reg.bus_latch_enable <= CTRL_WDATA_IN.bus_latch_enable ||
                                            array_control_reg.high_voltage_enable;
      // Enable is refused after a stray write with the latch clear
      array_control_reg.high_voltage_enable <= CTRL_WDATA_IN.high_voltage_enable &&
          !(!array_control_reg.bus_latch_enable && nonarray_wr);
    end
  end

  // Non-array write seen with the latch clear; set wins over the clear
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      nonarray_wr <= 1'b0;
    end else if (MEM_WR_IN && !acc_valid && !array_control_reg.bus_latch_enable) begin
      nonarray_wr <= 1'b1;
    end else if (ctrl_wr_ok && CTRL_WDATA_IN.bus_latch_enable) begin
      nonarray_wr <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Address and data latch
  // ------------------------------------------------------------
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      latched_valid <= 1'b0;
      latched_addr  <= 16'h0000;
      latched_data  <= 8'h00;
    end else if (!array_control_reg.bus_latch_enable) begin
      // Latch empties one cycle after the latch bit falls
      latched_valid <= 1'b0;
    end else if (MEM_WR_IN && acc_valid && !array_control_reg.high_voltage_enable) begin
      // Writes under voltage are ignored so the target cannot move mid-pulse
      latched_valid <= 1'b1;
      latched_addr  <= acc_addr;
      latched_data  <= MEM_ACCESS_IN.data;
    end
  end

  // ------------------------------------------------------------
  // Array update at the moment high voltage is applied
  // ------------------------------------------------------------
  // The cells change once per voltage pulse; pulse length is software's job
  for (genvar g = 0; g < `EEPEC_ARRAY_BYTES; g++) begin : g_cell
    // Each cell compares its own fixed index against the latched target
    localparam logic [`EEPEC_IDX_MSB:0] CELL_IDX = (`EEPEC_IDX_MSB+1)'(g);

    always_ff @(posedge MCLK_IN) begin
      if (hv_start && lat_in_array) begin
        unique case (mode)
          eepec_pkg::EEPEC_BYTE_PROGRAM: begin
            if (CELL_IDX == lat_idx) begin
              mem[g] <= mem[g] & latched_data;
            end
          end
          eepec_pkg::EEPEC_BYTE_ERASE: begin
            if (CELL_IDX == lat_idx) begin
              mem[g] <= `EEPEC_ERASED_BYTE;
            end
          end
          eepec_pkg::EEPEC_BLOCK_ERASE: begin
            if (CELL_IDX[`EEPEC_BLK_MSB:`EEPEC_BLK_LSB] == lat_block) begin
              mem[g] <= `EEPEC_ERASED_BYTE;
            end
          end
          eepec_pkg::EEPEC_BULK_ERASE: begin
            mem[g] <= `EEPEC_ERASED_BYTE;
          end
        endcase
      end
    end
  end

  // Configuration byte: byte operations only, frozen once security is armed
  // Bits only fall under programming, as in the array cells
  always_ff @(posedge MCLK_IN) begin
    if (hv_start && lat_is_nvcfg && !sec_armed) begin
      unique case (mode)
        eepec_pkg::EEPEC_BYTE_PROGRAM: begin
          nonvolatile_config_byte <= nonvolatile_config_byte & latched_data;
        end
        eepec_pkg::EEPEC_BYTE_ERASE: begin
          nonvolatile_config_byte <= `EEPEC_ERASED_BYTE;
        end
        eepec_pkg::EEPEC_BLOCK_ERASE,
        eepec_pkg::EEPEC_BULK_ERASE: begin
          nonvolatile_config_byte <= nonvolatile_config_byte;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Volatile configuration copy
  // ------------------------------------------------------------
  // Protection follows this copy, so a new stored byte waits for a reload
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      volatile_array_config <= nonvolatile_config_byte;
    end else if (MEM_RD_IN && acc_is_nvcfg) begin
      volatile_array_config <= nonvolatile_config_byte;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // While a target is latched, array reads show it instead of the cells
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      MEM_RDATA_OUT <= 8'h00;
    end else if (MEM_RD_IN) begin
      if (acc_is_nvcfg) begin
        MEM_RDATA_OUT <= nonvolatile_config_byte;
      end else if (acc_in_array && array_control_reg.bus_latch_enable && latched_valid) begin
        MEM_RDATA_OUT <= latched_data;
      end else if (acc_in_array) begin
        MEM_RDATA_OUT <= mem[acc_addr[`EEPEC_IDX_MSB:0]];
      end else begin
        MEM_RDATA_OUT <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // Status outputs
  // ------------------------------------------------------------
  // Pump and array switch share one enable, so they never disagree
  assign CTRL_STATUS_OUT = array_control_reg;
  assign VOL_CFG_OUT     = volatile_array_config;
  assign LATCH_VALID_OUT = latched_valid;
  assign PUMP_ON_OUT     = hv_applied;
  assign HV_APPLIED_OUT  = hv_applied;

endmodule

`default_nettype wire

// ===== test/eepec_chk.sv
// Port-level assertion checker for the EEPROM program and erase control block
`default_nettype none
`include "eepec_params.svh"
module eepec_chk (
  input wire logic                     MCLK_IN,
  input wire logic                     SYS_RST_IN,
  input wire logic                     CTRL_WR_IN,
  input wire eepec_pkg::eepec_ctrl_t   CTRL_WDATA_IN,
  input wire logic                     MEM_WR_IN,
  input wire logic                     MEM_RD_IN,
  input wire eepec_pkg::eepec_access_t MEM_ACCESS_IN,
  input wire logic [7:0]               MEM_RDATA_OUT,
  input wire eepec_pkg::eepec_ctrl_t   CTRL_STATUS_OUT,
  input wire logic [7:0]               VOL_CFG_OUT,
  input wire logic                     LATCH_VALID_OUT,
  input wire logic                     PUMP_ON_OUT,
  input wire logic                     HV_APPLIED_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hv;
  logic lat;
  logic arr;
  logic cfg;
  assign hv  = CTRL_STATUS_OUT.high_voltage_enable;
  assign lat = CTRL_STATUS_OUT.bus_latch_enable;
  assign arr = MEM_ACCESS_IN.addr inside {[`EEPEC_ARRAY_FIRST:`EEPEC_ARRAY_LAST]};
  assign cfg = MEM_ACCESS_IN.addr == `EEPEC_NVCFG_ADDR;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  pump_tracks_hv_a: assert property (PUMP_ON_OUT == HV_APPLIED_OUT)
    else $error("pump and array voltage disagree");
  hv_cause_a: assert property (HV_APPLIED_OUT |-> $past(hv) && $past(LATCH_VALID_OUT))
    else $error("voltage applied without enable and latched write");
  hv_drop_a: assert property (!hv |=> !HV_APPLIED_OUT)
    else $error("voltage still applied after enable cleared");
  clear_both_a: assert property (CTRL_WR_IN && hv && lat && LATCH_VALID_OUT
      && CTRL_WDATA_IN[1:0] == 2'b00 |=> lat && !hv)
    else $error("clearing both bits did not keep the latch");
  ctrl_lock_a: assert property (CTRL_WR_IN && lat && !LATCH_VALID_OUT
      |=> $stable(CTRL_STATUS_OUT))
    else $error("control write taken before a latched write");
  mode_freeze_a: assert property (hv |=> CTRL_STATUS_OUT[3:2] == $past(CTRL_STATUS_OUT[3:2]))
    else $error("mode bits changed while voltage enabled");
  latch_need_a: assert property (LATCH_VALID_OUT |-> $past(lat))
    else $error("latched write shown without latch bit");
  latch_capture_a: assert property (MEM_WR_IN && !CTRL_WR_IN && lat && !hv && arr
      |=> LATCH_VALID_OUT)
    else $error("valid array write not latched");
  cfg_copy_a: assert property (MEM_RD_IN && cfg |=> VOL_CFG_OUT == MEM_RDATA_OUT)
    else $error("config read did not reload the volatile copy");
  cfg_hold_a: assert property (!(MEM_RD_IN && cfg) |=> $stable(VOL_CFG_OUT))
    else $error("volatile copy changed without config read");
  cover property ($rose(HV_APPLIED_OUT));
  cover property (MEM_RD_IN && cfg);
  cover property (CTRL_WR_IN && lat && !LATCH_VALID_OUT);
endmodule

bind eepec_top eepec_chk eepec_chk_i (.MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .CTRL_WR_IN(CTRL_WR_IN), .CTRL_WDATA_IN(CTRL_WDATA_IN), .MEM_WR_IN(MEM_WR_IN),
  .MEM_RD_IN(MEM_RD_IN), .MEM_ACCESS_IN(MEM_ACCESS_IN), .MEM_RDATA_OUT(MEM_RDATA_OUT),
  .CTRL_STATUS_OUT(CTRL_STATUS_OUT), .VOL_CFG_OUT(VOL_CFG_OUT),
  .LATCH_VALID_OUT(LATCH_VALID_OUT), .PUMP_ON_OUT(PUMP_ON_OUT),
  .HV_APPLIED_OUT(HV_APPLIED_OUT));
`default_nettype wire

// ===== test/eepec_cpu_model.sv
// Processor-side model that drives control and memory strobes of the block
`default_nettype none
module eepec_cpu_model (
  input  wire logic                     clk_in,
  input  wire logic [7:0]               rdata_in,
  output var  logic                     ctrl_wr_out,
  output var  eepec_pkg::eepec_ctrl_t   ctrl_wdata_out,
  output var  logic                     mem_wr_out,
  output var  logic                     mem_rd_out,
  output var  eepec_pkg::eepec_access_t mem_access_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctrl_wr_out = 1'b0;
    ctrl_wdata_out = 4'h0;
    mem_wr_out = 1'b0;
    mem_rd_out = 1'b0;
    mem_access_out = 24'h000000;
  end
  // Released lines show the inverse so a stale value can never pass for a fresh one
  task automatic ctrl_wr(input logic [3:0] bits);
    @(negedge clk_in);
    ctrl_wr_out = 1'b1;
    ctrl_wdata_out = bits;
    @(negedge clk_in);
    ctrl_wr_out = 1'b0;
    ctrl_wdata_out = ~bits;
  endtask
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_in);
    mem_wr_out = wr;
    mem_rd_out = !wr;
    mem_access_out = {a, d};
    @(negedge clk_in);
    q = rdata_in;
    mem_wr_out = 1'b0;
    mem_rd_out = 1'b0;
    mem_access_out = ~{a, d};
  endtask
  // Timed waits are shortened; the array changes once, when voltage first lands
  task automatic run_op(input logic [1:0] mode, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    ctrl_wr({mode, 2'b10});
    acc(1'b1, a, d, q);
    ctrl_wr({mode, 2'b11});
    repeat (4) @(negedge clk_in);
    ctrl_wr({mode, 2'b10});
    repeat (2) @(negedge clk_in);
    ctrl_wr({mode, 2'b00});
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the EEPROM program and erase control block
`default_nettype none
`include "eepec_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     ctrl_wr;
  eepec_pkg::eepec_ctrl_t   ctrl_wdata;
  logic                     mem_wr;
  logic                     mem_rd;
  eepec_pkg::eepec_access_t mem_access;
  logic [7:0]               rdata;
  eepec_pkg::eepec_ctrl_t   status;
  logic [7:0]               vol_cfg;
  logic                     latch_valid;
  logic                     pump_on;
  logic                     hv_applied;
  logic                     pump_seen = 1'b0;
  logic [7:0]               q;
  int                       n_errors = 0;
  int                       checks_done = 0;
  int                       cycles = 0;
  localparam logic [15:0] CFG = `EEPEC_NVCFG_ADDR;
  always #4 clk = ~clk;
  eepec_top eepec_top_i (.MCLK_IN(clk), .SYS_RST_IN(rst), .CTRL_WR_IN(ctrl_wr),
    .CTRL_WDATA_IN(ctrl_wdata), .MEM_WR_IN(mem_wr), .MEM_RD_IN(mem_rd),
    .MEM_ACCESS_IN(mem_access), .MEM_RDATA_OUT(rdata), .CTRL_STATUS_OUT(status),
    .VOL_CFG_OUT(vol_cfg), .LATCH_VALID_OUT(latch_valid), .PUMP_ON_OUT(pump_on),
    .HV_APPLIED_OUT(hv_applied));
  eepec_cpu_model cpu_i (.clk_in(clk), .rdata_in(rdata), .ctrl_wr_out(ctrl_wr),
    .ctrl_wdata_out(ctrl_wdata), .mem_wr_out(mem_wr), .mem_rd_out(mem_rd),
    .mem_access_out(mem_access));
  // Sampled off the launching edge so the pump flag never races it
  always @(negedge clk) begin
    if (pump_on === 1'b1) pump_seen = 1'b1;
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    cpu_i.acc(1'b0, a, 8'h00, q);
    chk(q, exp, what);
  endtask
  // Reset is held ten cycles; the array and config byte survive it
  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic t_reset(input logic [7:0] cfg_exp);
    chk({4'h0, status}, 8'h00, "status after reset");
    chk(vol_cfg, cfg_exp, "config copy at reset");
  endtask
  task automatic t_program();
    pump_seen = 1'b0;
    cpu_i.run_op(2'b00, 16'h0605, 8'h5a);
    chk({7'h0, pump_seen}, 8'h01, "pump during program");
    chk({7'h0, hv_applied}, 8'h00, "voltage removed");
    rdchk(16'h0605, 8'h5a, "programmed byte");
    cpu_i.run_op(2'b00, 16'h0605, 8'ha5);
    rdchk(16'h0605, 8'h00, "bits only cleared");
    cpu_i.run_op(2'b01, 16'h0605, 8'h00);
    rdchk(16'h0605, 8'hff, "byte erase");
  endtask
  task automatic t_latch();
    cpu_i.ctrl_wr(4'b0010);
    cpu_i.ctrl_wr(4'b1010);
    chk({4'h0, status}, 8'h02, "control locked");
    cpu_i.acc(1'b1, 16'h0610, 8'h11, q);
    cpu_i.acc(1'b1, 16'h1234, 8'h33, q);
    cpu_i.acc(1'b1, 16'h0620, 8'h22, q);
    rdchk(16'h0700, 8'h22, "read of latched data");
    cpu_i.ctrl_wr(4'b0011);
    cpu_i.ctrl_wr(4'b1100);
    chk({4'h0, status}, 8'h02, "clear both keeps latch");
    cpu_i.ctrl_wr(4'b0000);
    rdchk(16'h0620, 8'h22, "last write won");
    rdchk(16'h0610, 8'hff, "first write replaced");
    cpu_i.acc(1'b1, 16'h1234, 8'h00, q);
    cpu_i.ctrl_wr(4'b0001);
    chk({4'h0, status}, 8'h00, "voltage refused");
  endtask
  task automatic t_erase();
    cpu_i.run_op(2'b00, 16'h0700, 8'h00);
    cpu_i.run_op(2'b00, 16'h077f, 8'h0f);
    cpu_i.run_op(2'b00, 16'h0605, 8'h3c);
    cpu_i.run_op(2'b10, 16'h0750, 8'h00);
    rdchk(16'h0700, 8'hff, "block erase low");
    rdchk(16'h077f, 8'hff, "block erase high");
    rdchk(16'h0605, 8'h3c, "other block kept");
    cpu_i.run_op(2'b11, 16'h0680, 8'h00);
    rdchk(16'h0605, 8'hff, "bulk erase");
    rdchk(CFG, 8'h10, "config kept by bulk");
  endtask
  task automatic t_protect();
    cpu_i.run_op(2'b01, CFG, 8'h00);
    chk(vol_cfg, 8'h10, "copy waits for reload");
    cpu_i.run_op(2'b00, 16'h0600, 8'h00);
    rdchk(16'h0600, 8'h00, "old protection in force");
    rdchk(CFG, 8'hff, "erased config");
    chk(vol_cfg, 8'hff, "copy reloaded");
    pump_seen = 1'b0;
    cpu_i.run_op(2'b01, 16'h0600, 8'h00);
    chk({7'h0, pump_seen}, 8'h00, "no voltage when protected");
    rdchk(16'h0600, 8'h00, "protected byte kept");
    cpu_i.run_op(2'b00, CFG, 8'h12);
    rdchk(CFG, 8'h12, "one block protected");
    cpu_i.run_op(2'b11, 16'h0600, 8'h00);
    rdchk(16'h0600, 8'h00, "bulk blocked");
    cpu_i.run_op(2'b01, 16'h0600, 8'h00);
    rdchk(16'h0600, 8'hff, "block 0 free");
    cpu_i.run_op(2'b00, 16'h0680, 8'h00);
    rdchk(16'h0680, 8'hff, "block 1 guarded");
    cpu_i.run_op(2'b00, CFG, 8'h10);
    do_reset();
    t_reset(8'h10);
  endtask
  task automatic t_secure();
    cpu_i.run_op(2'b00, CFG, 8'h00);
    pump_seen = 1'b0;
    cpu_i.run_op(2'b01, CFG, 8'h00);
    cpu_i.run_op(2'b10, 16'h0600, 8'h00);
    chk({7'h0, pump_seen}, 8'h00, "secured erase modes");
    rdchk(CFG, 8'h00, "config frozen");
    cpu_i.run_op(2'b00, 16'h0600, 8'h00);
    cpu_i.run_op(2'b01, 16'h0600, 8'h00);
    rdchk(16'h0600, 8'hff, "byte erase still works");
    cpu_i.ctrl_wr(4'b0010);
    cpu_i.acc(1'b1, `EEPEC_SECURE_FIRST, 8'h00, q);
    chk({7'h0, latch_valid}, 8'h00, "secured write not latched");
    cpu_i.acc(1'b1, 16'h0600, 8'hff, q);
    cpu_i.ctrl_wr(4'b0000);
  endtask
  initial begin
    do_reset();
    t_reset(8'h10);
    t_program();
    t_latch();
    t_erase();
    t_protect();
    t_secure();
    report_and_stop();
  end
endmodule
`default_nettype wire
